// >>> irm_mailbox.sv
`timescale 1ns/1ps
module irm_mailbox
    import irm_pkg::*;
(
    input wire logic core_clk,                       // System clock, 50 MHz
    input wire logic rstn,                           // Any reset, active low
    // Supervisory (master) core register port
    input wire logic [IRM_ADDR_W-1:0] m_addr,        // Master address
    input wire logic m_wr,                           // Master write strobe
    input wire logic m_rd,                           // Master read strobe
    input wire logic [IRM_DATA_W-1:0] m_wdata,       // Master write data
    output logic [IRM_DATA_W-1:0] m_rdata,           // Master read data
    // Processing (slave) core register port
    input wire logic [IRM_ADDR_W-1:0] s_addr,        // Slave address
    input wire logic s_wr,                           // Slave write strobe
    input wire logic s_rd,                           // Slave read strobe
    input wire logic [IRM_DATA_W-1:0] s_wdata,       // Slave write data
    output logic [IRM_DATA_W-1:0] s_rdata,           // Slave read data
    // Response side
    input wire logic slave_response_status,          // Response data-valid flag
    output logic response_irq,                       // Response interrupt request
    output logic command_valid_flag,                 // Mailbox holds a request
    output logic [IRM_CMD_W-1:0] command_code_field  // Current command code
);

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_n;

    irm_rst_sync u_rst (
        .core_clk(core_clk),
        .rstn(rstn),
        .rst_sync_n(rst_n)
    );

    // ----------------------------------------------------------------
    // State of the mailbox
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [IRM_CMD_W-1:0] cmd;
        logic irq_en;
        logic valid;
        logic [IRM_DATA_W-1:0] word_a;
        logic [IRM_DATA_W-1:0] word_b;
        logic irq;
    } irm_state_t;

    irm_state_t st_r;
    irm_state_t st_nxt;

    // Control register as both cores see it; upper byte and bits 7:6 zero
    logic [IRM_DATA_W-1:0] ctrl_view;

    always_comb begin
        ctrl_view = '0;
        ctrl_view[IRM_CMD_LSB +: IRM_CMD_W] = st_r.cmd;
        ctrl_view[IRM_IRQ_EN_BIT] = st_r.irq_en;
        ctrl_view[IRM_VALID_BIT] = st_r.valid;
    end

    // ----------------------------------------------------------------
    // Per-core access decode and read data
    // ----------------------------------------------------------------
    irm_sel_t m_sel;
    irm_sel_t s_sel;

    irm_core_port u_mport (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .addr(m_addr),
        .rd(m_rd),
        .ctrl_view(ctrl_view),
        .word_a(st_r.word_a),
        .word_b(st_r.word_b),
        .sel(m_sel),
        .rdata(m_rdata)
    );

    irm_core_port u_sport (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .addr(s_addr),
        .rd(s_rd),
        .ctrl_view(ctrl_view),
        .word_a(st_r.word_a),
        .word_b(st_r.word_b),
        .sel(s_sel),
        .rdata(s_rdata)
    );

    // ----------------------------------------------------------------
    // Write qualifiers
    // ----------------------------------------------------------------
    logic m_wr_ctrl;
    logic m_wr_a;
    logic m_wr_b;
    logic s_wr_ctrl;
    logic valid_set;
    logic valid_clr;

    // Only the master may change command, enable and follow-on words
    assign m_wr_ctrl = m_wr && (m_sel == IRM_SEL_CONTROL);
    assign m_wr_a = m_wr && (m_sel == IRM_SEL_WORD_A);
    assign m_wr_b = m_wr && (m_sel == IRM_SEL_WORD_B);
    assign s_wr_ctrl = s_wr && (s_sel == IRM_SEL_CONTROL);

    // Master writing one sets; a master zero is ignored
    assign valid_set = m_wr_ctrl && m_wdata[IRM_VALID_BIT];
    // Slave writing zero clears; a slave one never sets
    assign valid_clr = s_wr_ctrl && !s_wdata[IRM_VALID_BIT];

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    // A new request posted in the very cycle the slave clears the flag
    // must not be lost, so the master's set wins over the slave's clear.
    always_comb begin
        st_nxt = st_r;
        if (m_wr_ctrl) begin
            st_nxt.cmd = m_wdata[IRM_CMD_LSB +: IRM_CMD_W];
            st_nxt.irq_en = m_wdata[IRM_IRQ_EN_BIT];
        end
        if (valid_set) begin
            st_nxt.valid = 1'b1;
        end else if (valid_clr) begin
            st_nxt.valid = 1'b0;
        end
        // Full word stored; no lock while valid is set, the master polls
        if (m_wr_a) begin
            st_nxt.word_a = m_wdata;
        end
        if (m_wr_b) begin
            st_nxt.word_b = m_wdata;
        end
        // Interrupt follows the response flag only while enabled
        st_nxt.irq = st_r.irq_en && slave_response_status;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r.cmd <= IRM_CMD_RST;
            st_r.irq_en <= IRM_CONTROL_RST[IRM_IRQ_EN_BIT];
            st_r.valid <= IRM_CONTROL_RST[IRM_VALID_BIT];
            st_r.word_a <= IRM_WORD_A_RST;
            st_r.word_b <= IRM_WORD_B_RST;
            st_r.irq <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from the state register
    // ----------------------------------------------------------------
    assign response_irq = st_r.irq;
    assign command_valid_flag = st_r.valid;
    assign command_code_field = st_r.cmd;

endmodule

// >>> irm_pkg.sv
package irm_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int IRM_ADDR_W = 8;
    localparam int IRM_DATA_W = 16;
    localparam int IRM_CMD_W = 4;
    localparam int IRM_CTRL_W = 8;

    // ----------------------------------------------------------------
    // Register offsets in the special-function space
    // ----------------------------------------------------------------
    localparam logic [7:0] IRM_OFS_CONTROL = 8'h0e;
    localparam logic [7:0] IRM_OFS_WORD_A = 8'h0f;
    localparam logic [7:0] IRM_OFS_WORD_B = 8'h10;

    // ----------------------------------------------------------------
    // Control register field positions
    // ----------------------------------------------------------------
    localparam int IRM_CMD_LSB = 0;
    localparam int IRM_IRQ_EN_BIT = 4;
    localparam int IRM_VALID_BIT = 5;

    // ----------------------------------------------------------------
    // Values after reset
    // ----------------------------------------------------------------
    localparam logic [7:0] IRM_CONTROL_RST = 8'h00;
    localparam logic [15:0] IRM_WORD_A_RST = 16'h0000;
    localparam logic [15:0] IRM_WORD_B_RST = 16'h0000;
    localparam logic [3:0] IRM_CMD_RST = 4'h0;

    // Stages of the reset release synchroniser
    localparam int IRM_RST_STAGES = 2;

    // Register selected by an access
    typedef enum logic [1:0] {
        IRM_SEL_NONE,
        IRM_SEL_CONTROL,
        IRM_SEL_WORD_A,
        IRM_SEL_WORD_B
    } irm_sel_t;

endpackage

// >>> irm_rst_sync.sv
`timescale 1ns/1ps
module irm_rst_sync
    import irm_pkg::*;
(
    input wire logic core_clk,  // System clock
    input wire logic rstn,      // Asynchronous reset, active low
    output logic rst_sync_n     // Released reset, active low
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [IRM_RST_STAGES-1:0] chain;
    } irm_rst_state_t;

    irm_rst_state_t st_r;
    irm_rst_state_t st_nxt;

    // Shift ones in after release; assert at once, release on the clock
    always_comb begin
        st_nxt = st_r;
        st_nxt.chain = {st_r.chain[IRM_RST_STAGES-2:0], 1'b1};
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rst_sync_n = st_r.chain[IRM_RST_STAGES-1];

endmodule

// >>> irm_core_port.sv
`timescale 1ns/1ps
module irm_core_port
    import irm_pkg::*;
(
    input wire logic core_clk,                    // System clock
    input wire logic rst_n,                       // Synchronised reset, active low
    input wire logic [IRM_ADDR_W-1:0] addr,       // Register address
    input wire logic rd,                          // Read strobe
    input wire logic [IRM_DATA_W-1:0] ctrl_view,  // Control register as read
    input wire logic [IRM_DATA_W-1:0] word_a,     // Follow-on word A
    input wire logic [IRM_DATA_W-1:0] word_b,     // Follow-on word B
    output irm_sel_t sel,                         // Register addressed now
    output logic [IRM_DATA_W-1:0] rdata           // Registered read data
);

    // ----------------------------------------------------------------
    // Address decode, shared by read and write paths
    // ----------------------------------------------------------------
    function automatic irm_sel_t irm_decode(input logic [IRM_ADDR_W-1:0] a);
        irm_sel_t s;
        s = IRM_SEL_NONE;
        case (a)
            IRM_OFS_CONTROL: s = IRM_SEL_CONTROL;
            IRM_OFS_WORD_A: s = IRM_SEL_WORD_A;
            IRM_OFS_WORD_B: s = IRM_SEL_WORD_B;
            default: s = IRM_SEL_NONE;
        endcase
        return s;
    endfunction

    typedef struct packed {
        logic [IRM_DATA_W-1:0] rdata;
    } irm_port_state_t;

    irm_port_state_t st_r;
    irm_port_state_t st_nxt;

    assign sel = irm_decode(addr);

    // Read data held until the next read; unmapped addresses read zero
    always_comb begin
        st_nxt = st_r;
        if (rd) begin
            case (irm_decode(addr))
                IRM_SEL_CONTROL: st_nxt.rdata = ctrl_view;
                IRM_SEL_WORD_A: st_nxt.rdata = word_a;
                IRM_SEL_WORD_B: st_nxt.rdata = word_b;
                default: st_nxt.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;

endmodule

// >>> irm_mailbox_checker.sv
`timescale 1ns/1ps
module irm_mailbox_checker (
    input wire logic core_clk, // Clock
    input wire logic rstn, // Reset, low
    input wire logic [7:0] m_addr, // Master address
    input wire logic m_wr, // Master write
    input wire logic [15:0] m_wdata, // Master data
    input wire logic [7:0] s_addr, // Slave address
    input wire logic s_wr, // Slave write
    input wire logic s_rd, // Slave read
    input wire logic [15:0] s_wdata, // Slave data
    input wire logic [15:0] s_rdata, // Slave read data
    input wire logic slave_response_status, // Response flag
    input wire logic response_irq, // Interrupt
    input wire logic command_valid_flag, // Valid flag
    input wire logic [3:0] command_code_field // Command
);
    // Control writes; en_r shadows the enable bit, which has no port
    logic mc, ms, sc, en_r;
    assign mc = m_wr && m_addr == 8'h0e;
    assign ms = mc && m_wdata[5];
    assign sc = s_wr && s_addr == 8'h0e && !s_wdata[5];
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) en_r <= 1'b0;
        else if (mc) en_r <= m_wdata[4];
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_valid_set: assert property (ms |=> command_valid_flag) else $error("valid not set");
    a_valid_clr: assert property (sc && !ms |=> !command_valid_flag) else $error("valid not cleared");
    a_valid_hold: assert property (!ms && !sc |=> $stable(command_valid_flag)) else $error("valid moved");
    a_cmd_load: assert property (mc |=> command_code_field == $past(m_wdata[3:0])) else $error("cmd");
    a_cmd_hold: assert property (!mc |=> $stable(command_code_field)) else $error("cmd moved");
    a_irq_on: assert property (en_r && slave_response_status |=> response_irq) else $error("irq low");
    a_irq_off: assert property (!(en_r && slave_response_status) |=> !response_irq) else $error("irq");
    a_ctrl_read: assert property (s_rd && s_addr == 8'h0e |=> s_rdata ==
        {10'h000, $past(command_valid_flag), $past(en_r), $past(command_code_field)}) else $error("ctrl");
    a_reset_zero: assert property ($rose(rstn) |-> !command_valid_flag && command_code_field == 4'h0)
        else $error("not cleared");
endmodule
bind irm_mailbox irm_mailbox_checker u_chk (.core_clk(core_clk), .rstn(rstn), .m_addr(m_addr), .m_wr(m_wr),
    .m_wdata(m_wdata), .s_addr(s_addr), .s_wr(s_wr), .s_rd(s_rd), .s_wdata(s_wdata), .s_rdata(s_rdata),
    .slave_response_status(slave_response_status), .response_irq(response_irq),
    .command_valid_flag(command_valid_flag), .command_code_field(command_code_field));

// >>> irm_slave_model.sv
`timescale 1ns/1ps
module irm_slave_model (
    input wire logic core_clk, // Clock
    input wire logic [15:0] s_rdata, // Read data
    output logic [7:0] s_addr = 8'h5a, // Address
    output logic s_wr = 1'b0, // Write
    output logic s_rd = 1'b0, // Read
    output logic [15:0] s_wdata = 16'ha5a5, // Write data
    output logic slave_response_status = 1'b0 // Response flag
);
    // One-cycle access; idle bus shows the inverse so nothing stale looks valid
    task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
        @(posedge core_clk);
        s_wr <= w;
        s_rd <= !w;
        s_addr <= a;
        s_wdata <= d;
        @(posedge core_clk);
        s_wr <= 1'b0;
        s_rd <= 1'b0;
        s_addr <= ~a;
        s_wdata <= ~d;
        #1 q = s_rdata;
    endtask
    // Response flag level driven by the slave's own response logic
    task automatic status(input logic v);
        @(posedge core_clk);
        slave_response_status <= v;
    endtask
endmodule

// >>> intercore_request_mailbox_tb.sv
`timescale 1ns/1ps
module intercore_request_mailbox_tb;
    logic core_clk = 0, rstn = 0, m_wr = 0, m_rd = 0, s_wr, s_rd, sts, irq, vld;
    logic [7:0] m_addr = 0, s_addr;
    logic [15:0] m_wdata = 0, m_rdata, s_wdata, s_rdata, q;
    logic [3:0] cmd;
    logic [31:0] r;
    logic [7:0] tbl [4] = '{8'h0e, 8'h0f, 8'h10, 8'h11};
    int mismatches = 0, cmp_count = 0, m_cmd, m_en, m_vld, m_wa, m_wb;
    int unsigned seed = 32949;
    always #10 core_clk = ~core_clk;
    irm_mailbox dut (.core_clk(core_clk), .rstn(rstn), .m_addr(m_addr), .m_wr(m_wr), .m_rd(m_rd),
        .m_wdata(m_wdata), .m_rdata(m_rdata), .s_addr(s_addr), .s_wr(s_wr), .s_rd(s_rd), .s_wdata(s_wdata),
        .s_rdata(s_rdata), .slave_response_status(sts), .response_irq(irq), .command_valid_flag(vld),
        .command_code_field(cmd));
    irm_slave_model slv (.core_clk(core_clk), .s_rdata(s_rdata), .s_addr(s_addr), .s_wr(s_wr), .s_rd(s_rd),
        .s_wdata(s_wdata), .slave_response_status(sts));
    // Stimulus source and reference model
    function automatic int unsigned xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] exp_rd(input logic [7:0] a);
        case (a)
            8'h0e: return 16'(m_vld * 32 + m_en * 16 + m_cmd);
            8'h0f: return 16'(m_wa);
            8'h10: return 16'(m_wb);
            default: return 16'h0000;
        endcase
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Master access; a read is compared, a write updates the model
    task automatic macc(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        m_wr <= w;
        m_rd <= !w;
        m_addr <= a;
        m_wdata <= d;
        @(posedge core_clk);
        m_wr <= 0;
        m_rd <= 0;
        m_addr <= ~a;
        #1;
        if (!w) chk(m_rdata, exp_rd(a));
        else if (a == 8'h0e) begin
            // Master one sets the flag, master zero leaves it alone
            m_vld = m_vld | int'(d[5]);
            m_en = int'(d[4]);
            m_cmd = int'(d[3:0]);
        end
        else if (a == 8'h0f) m_wa = d;
        else if (a == 8'h10) m_wb = d;
        chk({11'h0, vld, cmd}, 16'(m_vld * 16 + m_cmd));
    endtask
    // Slave access; only a control write with bit 5 low does anything
    task automatic sacc(input logic w, input logic [7:0] a, input logic [15:0] d);
        slv.access(w, a, d, q);
        if (!w) chk(q, exp_rd(a));
        else if (a == 8'h0e && !d[5]) m_vld = 0;
        chk({11'h0, vld, cmd}, 16'(m_vld * 16 + m_cmd));
    endtask
    task automatic do_reset();
        @(posedge core_clk);
        rstn <= 0;
        {m_cmd, m_en, m_vld, m_wa, m_wb} = 0;
        repeat (3) @(posedge core_clk);
        rstn <= 1;
        repeat (3) @(posedge core_clk);
        for (int i = 0; i < 4; i++) macc(0, tbl[i], 0);
    endtask
    initial begin
        do_reset();
        macc(1, 8'h0e, 16'h00e7);
        macc(0, 8'h0e, 0);
        macc(1, 8'h0e, 16'h0019);
        sacc(1, 8'h0e, 16'h003f);
        sacc(1, 8'h0e, 16'h0000);
        sacc(1, 8'h0e, 16'h0020);
        macc(1, 8'h0f, 16'hffff);
        macc(1, 8'h10, 16'h8001);
        for (int i = 0; i < 4; i++) sacc(1, tbl[i], 16'h0f0f);
        for (int i = 0; i < 4; i++) sacc(0, tbl[i], 0);
        // Interrupt follows enable and response flag with one cycle of delay
        slv.status(1);
        repeat (2) @(posedge core_clk);
        #1 chk({15'h0, irq}, 16'h0001);
        macc(1, 8'h0e, 16'h0009);
        @(posedge core_clk);
        #1 chk({15'h0, irq}, 16'h0000);
        // Set and clear in one cycle: the set is kept
        fork
            macc(1, 8'h0e, 16'h0025);
            slv.access(1, 8'h0e, 16'h0000, q);
        join
        // Slave takes the request, master polls the flag, then posts anew
        sacc(1, 8'h0e, 16'h0000);
        macc(0, 8'h0e, 0);
        macc(1, 8'h0f, 16'h5aa5);
        macc(1, 8'h0e, 16'h0023);
        for (int i = 0; i < 300; i++) begin
            r = xs();
            if (r[4]) slv.status(r[5]);
            if (r[1]) sacc(r[0], tbl[r[3:2]], r[31:16]);
            else macc(r[0], tbl[r[3:2]], r[31:16]);
        end
        macc(1, 8'h0e, 16'h003f);
        macc(1, 8'h10, 16'h1234);
        do_reset();
        finish_test();
    end
    // Run should end near 850 cycles
    initial begin
        repeat (8000) @(posedge core_clk);
        mismatches++;
        finish_test();
    end
endmodule
